// ==== src/sap_gray_enc.sv ====
// Binary to Gray code converter of parameterised width
`timescale 1ns/1ps
module sap_gray_enc
#(
    parameter int W = 24
)
(
    input wire logic [W-1:0] bin,
    output logic [W-1:0] gray
);

    // Neighbouring codes differ in one bit
    assign gray = bin ^ (bin >> 1);

endmodule

// ==== src/sap_pkg.sv ====
// Shared widths, timing constants and slot encodings of the serial position slave
package sap_pkg;

    // Word layout: turn count in the upper half, in-turn angle in the lower half
    localparam int WORD_W = 24;
    localparam int TURN_W = 12;
    localparam int ANGLE_W = 12;

    // Slot counter on the link side: number of bits already driven in this copy
    localparam int SLOT_W = 5;
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 5'h01;
    localparam logic [SLOT_W-1:0] SLOT_LSB = 5'h18;
    localparam logic [SLOT_W-1:0] SLOT_GAP = 5'h19;
    localparam logic [SLOT_W-1:0] SLOT_TOP = 5'h17;

    // Line levels
    localparam logic DATA_IDLE = 1'b1;
    localparam logic DATA_GAP = 1'b0;

    // System clock rate
    localparam int CLK_MHZ = 250;

    // Start-up delay, longest time, so rounded down
    localparam int STARTUP_MS = 450;
    localparam int STARTUP_CYCLES_DEF = STARTUP_MS * CLK_MHZ * 1000;
    localparam int STARTUP_CNT_W = 27;

    // Monoflop timeout, least time, so rounded up
    localparam int MONOFLOP_NS = 20000;
    localparam int MONOFLOP_CYCLES_DEF = (MONOFLOP_NS * CLK_MHZ + 999) / 1000;
    localparam int MONO_CNT_W = 16;

endpackage

// ==== src/sap_ssi_slave.sv ====
// Serial absolute position slave: snapshot, monoflop timing and link shifter
`timescale 1ns/1ps

// What this block and its controller must do
// RULE_01: With no transfer running the clock and data lines both rest high.
// RULE_02: The first falling clock edge after idle captures the current position and opens a transfer.
// RULE_03: The first rising clock edge of a transfer puts the captured word's top bit on the data line.
// RULE_04: Each later rising edge puts the next lower bit out, so the word goes top bit first.
// RULE_05: After the lowest bit the data line goes low and stays low until the monoflop timeout ends.
// RULE_06: The controller starts no new transfer before the data line is high again or the pause has run.
// RULE_07: Every falling clock edge restarts the monoflop timeout, so it runs from the last one of a burst.
// RULE_08: The controller keeps every clock period of a transfer shorter than the monoflop timeout.
// RULE_09: A word holds 24 bits, 12 turn bits and 12 in-turn bits.
// RULE_10: If clocking goes on after the last bit with no pause, the same captured word is sent again.
// RULE_11: If the pulse after the last bit comes later than the timeout, a fresh position is captured and sent.
// RULE_12: The word is Gray coded and counts up for clockwise turning.
// RULE_13: No valid position leaves the block before the start-up delay has passed.
// RULE_14: The controller wires the clock pair with the right polarity.
// RULE_15: The turn count fills the upper 12 bits, the angle the lower 12, Gray coding over the whole word.
// RULE_16: In repeat mode the controller compares copies and flags an error when they differ; sap_ctrl_model only shifts the bits in and compares nothing.
module sap_ssi_slave
    import sap_pkg::*;
#(
    parameter logic [STARTUP_CNT_W-1:0] STARTUP_CYCLES = STARTUP_CNT_W'(STARTUP_CYCLES_DEF),
    parameter logic [MONO_CNT_W-1:0] MONOFLOP_CYCLES = MONO_CNT_W'(MONOFLOP_CYCLES_DEF)
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [TURN_W-1:0] TURN_COUNT,
    input wire logic [ANGLE_W-1:0] ANGLE,
    input wire logic LINK_CLK,
    output logic DATA_OUT,
    output logic READY,
    output logic LINK_BUSY
);

    // ------------------------------------------------------------------
    // System clock domain
    // ------------------------------------------------------------------

    logic [WORD_W-1:0] pos_bin;
    logic [WORD_W-1:0] pos_gray;
    logic [WORD_W-1:0] snap_d;
    logic [WORD_W-1:0] snap_q;
    logic [STARTUP_CNT_W-1:0] boot_cnt_d;
    logic [STARTUP_CNT_W-1:0] boot_cnt_q;
    logic ready_d;
    logic ready_q;
    logic lclk_sync;
    logic lclk_prev_d;
    logic lclk_prev_q;
    logic lclk_fall;
    logic [MONO_CNT_W-1:0] mono_cnt_d;
    logic [MONO_CNT_W-1:0] mono_cnt_q;
    logic mono_idle_d;
    logic mono_idle_q;

    // Turn count above angle, both from the sensing logic
    assign pos_bin = {TURN_COUNT, ANGLE}; // [RULE_15] [RULE_09]

    // Whole word coded, so one shaft step flips a single bit
    sap_gray_enc #(
        .W(WORD_W)
    ) u_gray (
        .bin(pos_bin),
        .gray(pos_gray)
    ); // [RULE_12]

    // Snapshot follows the position once the sensor is trusted
    always_comb
    begin
        snap_d = snap_q;
        if (ready_q)
        begin
            snap_d = pos_gray; // [RULE_13]
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            snap_q <= '0;
        end
        else
        begin
            snap_q <= snap_d;
        end
    end

    // Start-up delay counter
    always_comb
    begin
        boot_cnt_d = boot_cnt_q;
        ready_d = ready_q;
        if (!ready_q)
        begin
            if (boot_cnt_q >= STARTUP_CYCLES - STARTUP_CNT_W'(1))
            begin
                ready_d = 1'b1; // [RULE_13]
            end
            else
            begin
                boot_cnt_d = boot_cnt_q + STARTUP_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            boot_cnt_q <= '0;
            ready_q <= 1'b0;
        end
        else
        begin
            boot_cnt_q <= boot_cnt_d;
            ready_q <= ready_d;
        end
    end

    // Link clock seen as a level, idle high
    sap_sync2 #(
        .RST_VAL(1'b1)
    ) u_lclk_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(LINK_CLK),
        .dout(lclk_sync)
    );

    // Falling edge of the synchronised link clock
    assign lclk_prev_d = lclk_sync;
    assign lclk_fall = lclk_prev_q & ~lclk_sync;

    // Monoflop: every falling edge reloads it, expiry returns to idle
    always_comb
    begin
        mono_cnt_d = mono_cnt_q;
        mono_idle_d = mono_idle_q;
        if (lclk_fall)
        begin
            mono_cnt_d = MONOFLOP_CYCLES; // [RULE_07]
            mono_idle_d = 1'b0;
        end
        else if (mono_cnt_q > MONO_CNT_W'(1))
        begin
            mono_cnt_d = mono_cnt_q - MONO_CNT_W'(1);
        end
        else if (mono_cnt_q == MONO_CNT_W'(1))
        begin
            mono_cnt_d = '0;
            mono_idle_d = 1'b1; // [RULE_05] [RULE_11]
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            lclk_prev_q <= 1'b1;
            mono_cnt_q <= '0;
            mono_idle_q <= 1'b1;
        end
        else
        begin
            lclk_prev_q <= lclk_prev_d;
            mono_cnt_q <= mono_cnt_d;
            mono_idle_q <= mono_idle_d;
        end
    end

    // ------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------
    // The link clock stops between frames, so no synchroniser can run on
    // it. mono_idle_q is quasi-static at a frame's first falling edge: it
    // settled a full timeout earlier as long as the pause is kept. snap_q
    // is Gray coded and moves one bit per step, so a sample taken while
    // it changes is either the old or the new position, and the half
    // link period before the first rising edge lets the flop settle.

    logic [WORD_W-1:0] cap_d;
    logic [WORD_W-1:0] cap_q;
    logic cap_tog_d;
    logic cap_tog_q;
    logic seen_tog_d;
    logic seen_tog_q;
    logic [SLOT_W-1:0] slot_d;
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] bit_idx;
    logic data_d;
    logic data_q;

    // Capture on the first falling edge after the timeout
    always_comb
    begin
        cap_d = cap_q;
        cap_tog_d = cap_tog_q;
        if (mono_idle_q)
        begin
            cap_d = snap_q; // [RULE_02] [RULE_11]
            cap_tog_d = ~cap_tog_q;
        end
    end

    always_ff @(negedge LINK_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cap_q <= '0;
            cap_tog_q <= 1'b0;
        end
        else
        begin
            cap_q <= cap_d;
            cap_tog_q <= cap_tog_d;
        end
    end

    // Bit to send after slot_q bits already went out
    assign bit_idx = SLOT_TOP - slot_q;

    // Shifter: top bit first, a low gap bit, then ring repetition
    always_comb
    begin
        seen_tog_d = cap_tog_q;
        slot_d = slot_q;
        data_d = data_q;
        if (cap_tog_q != seen_tog_q)
        begin
            data_d = cap_q[WORD_W-1]; // [RULE_03]
            slot_d = SLOT_FIRST;
        end
        else if (slot_q < SLOT_LSB)
        begin
            data_d = cap_q[bit_idx]; // [RULE_04]
            slot_d = slot_q + SLOT_W'(1);
        end
        else if (slot_q == SLOT_LSB)
        begin
            data_d = DATA_GAP; // [RULE_05]
            slot_d = SLOT_GAP;
        end
        else
        begin
            // No pause since the gap: same word again
            data_d = cap_q[WORD_W-1]; // [RULE_10]
            slot_d = SLOT_FIRST;
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            seen_tog_q <= 1'b0;
            slot_q <= SLOT_GAP;
            data_q <= DATA_GAP;
        end
        else
        begin
            seen_tog_q <= seen_tog_d;
            slot_q <= slot_d;
            data_q <= data_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Line high when idle or before start-up ends; OR of flops, no glitch
    assign DATA_OUT = data_q | mono_idle_q | ~ready_q; // [RULE_01] [RULE_05] [RULE_13]
    assign READY = ready_q;
    assign LINK_BUSY = ~mono_idle_q;

endmodule

// ==== src/sap_sync2.sv ====
// Two-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module sap_sync2
#(
    parameter logic RST_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);

    logic meta_q;
    logic sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

// ==== test/sap_ctrl_model.sv ====
// Behavioural serial controller that clocks words out of the slave
`timescale 1ns/1ps
module sap_ctrl_model
(
    output logic link_clk,
    input wire logic data_in
);
    // Clock rests high outside bursts
    initial link_clk = 1'b1;

    // Burst of n clocks at 15 ns, far inside the timeout
    // True polarity: fall first, data taken late in the high phase
    task automatic burst(input int n, output logic [63:0] bits);
        wait (data_in === 1'b1);
        bits = '0;
        repeat (n)
        begin
            link_clk = 1'b0;
            #7.5;
            link_clk = 1'b1;
            #7.5;
            bits = {bits[62:0], data_in};
        end
    endtask
endmodule

// ==== test/sap_ssi_chk.sv ====
// Checker for start-up, idle level and monoflop timing of the slave
`timescale 1ns/1ps
module sap_ssi_chk
    import sap_pkg::*;
#(
    parameter logic [STARTUP_CNT_W-1:0] STARTUP_CYCLES = STARTUP_CNT_W'(STARTUP_CYCLES_DEF),
    parameter logic [MONO_CNT_W-1:0] MONOFLOP_CYCLES = MONO_CNT_W'(MONOFLOP_CYCLES_DEF)
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic LINK_CLK,
    input wire logic DATA_OUT,
    input wire logic READY,
    input wire logic LINK_BUSY
);
    logic prev_q, prev_d;
    logic [MONO_CNT_W-1:0] quiet_q, quiet_d;
    logic [STARTUP_CNT_W-1:0] age_q, age_d;

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // Cycles since a raw clock fall; runs ahead of the slave's sync
    always_comb
    begin
        prev_d = LINK_CLK;
        quiet_d = (prev_q && !LINK_CLK) ? '0 : quiet_q + {15'h0000, quiet_q != '1};
        age_d = age_q + {26'h0000000, age_q != '1};
    end

    // Helper registers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            {prev_q, quiet_q, age_q} <= {1'b1, 16'hffff, 27'h0000000};
        else
            {prev_q, quiet_q, age_q} <= {prev_d, quiet_d, age_d};
    end

    sequence fall_s;
        READY && !LINK_BUSY && $fell(LINK_CLK);
    endsequence

    ready_time_a: assert property ($rose(READY) |-> age_q >= STARTUP_CYCLES - 27'h1
        && age_q <= STARTUP_CYCLES + 27'h1) else $error("ready rose at wrong time");
    ready_hold_a: assert property (READY |=> READY) else $error("ready dropped");
    pre_ready_a: assert property (!READY |-> DATA_OUT) else $error("data low before ready");
    busy_start_a: assert property (fall_s |-> ##[1:4] LINK_BUSY) else $error("fall did not start");
    busy_keep_a: assert property (LINK_BUSY && quiet_q < MONOFLOP_CYCLES |=> LINK_BUSY)
        else $error("timeout ended early");
    busy_end_a: assert property ($fell(LINK_BUSY) |-> quiet_q >= MONOFLOP_CYCLES
        && quiet_q <= MONOFLOP_CYCLES + 16'h6) else $error("timeout length off");
    busy_max_a: assert property (LINK_BUSY |-> quiet_q <= MONOFLOP_CYCLES + 16'h6)
        else $error("timeout overran");
    line_idle_a: assert property (quiet_q > MONOFLOP_CYCLES + 16'h6 |-> DATA_OUT && !LINK_BUSY)
        else $error("line not idle after timeout");
endmodule

bind sap_ssi_slave sap_ssi_chk #(.STARTUP_CYCLES(STARTUP_CYCLES), .MONOFLOP_CYCLES(MONOFLOP_CYCLES)) chk
    (.CLK(CLK), .ARST_N(ARST_N), .LINK_CLK(LINK_CLK), .DATA_OUT(DATA_OUT), .READY(READY), .LINK_BUSY(LINK_BUSY));

// ==== test/sap_ssi_slave_test.sv ====
// Self-checking bench for the serial position slave
`timescale 1ns/1ps
module sap_ssi_slave_test;
    import sap_pkg::*;
    localparam int START = 200;
    localparam int MONO = 40;
    logic clk, arst_n, link_clk, data_out, ready, link_busy;
    logic [TURN_W-1:0] turn;
    logic [ANGLE_W-1:0] angle;
    logic [63:0] rx;
    logic [WORD_W-1:0] g;
    int fails, num_checks;

    sap_ssi_slave #(.STARTUP_CYCLES(27'(START)), .MONOFLOP_CYCLES(16'(MONO))) uut (.CLK(clk), .ARST_N(arst_n),
        .TURN_COUNT(turn), .ANGLE(angle), .LINK_CLK(link_clk), .DATA_OUT(data_out), .READY(ready),
        .LINK_BUSY(link_busy));
    sap_ctrl_model ctrl (.link_clk(link_clk), .data_in(data_out));

    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Any step while idle: four cycles let the snapshot settle before the next capture
    task automatic set_pos(input logic [WORD_W-1:0] p);
        @(negedge clk);
        {turn, angle} = p;
        g = p ^ (p >> 1);
        repeat (4) @(negedge clk);
    endtask

    // Frames before ready give only the idle level
    task automatic t_startup;
        ctrl.burst(25, rx);
        check(rx[24:0], 25'h1ffffff);
        for (int i = 0; i < START && !ready; i++)
            @(negedge clk);
        check(ready, 1'b1);
        repeat (MONO + 10) @(negedge clk);
    endtask

    // One word, gap bit, then timeout back to idle
    task automatic t_frame(input logic [WORD_W-1:0] p);
        set_pos(p);
        ctrl.burst(25, rx);
        check(rx[24:0], {g, 1'b0});
        repeat (MONO - 8) @(negedge clk);
        check({link_busy, data_out}, 2'b10);
        repeat (14) @(negedge clk);
        check({link_busy, data_out}, 2'b01);
    endtask

    // Unbroken clocking repeats the old word though the input moved
    task automatic t_ring(input logic [WORD_W-1:0] p);
        set_pos(p);
        fork
            ctrl.burst(50, rx);
            begin
                repeat (30) @(negedge clk);
                turn = turn + 12'h001;
            end
        join
        check(rx[49:0], {g, 1'b0, g, 1'b0});
        repeat (MONO + 10) @(negedge clk);
    endtask

    initial
    begin
        arst_n = 1'b0;
        turn = '0;
        angle = '0;
        fails = 0;
        num_checks = 0;
        repeat (16) @(negedge clk);
        check({ready, data_out}, 2'b01);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_startup();
        t_ring(24'h7ff0ff);
        t_frame(24'h800100);
        t_frame(24'h800101);
        t_frame(24'hffffff);
        t_frame(24'h000001);
        finish_test();
    end

    // Watchdog well past the expected run of a few microseconds
    initial
    begin
        #40000;
        fails++;
        finish_test();
    end
endmodule
